// file: inc/tsrb_pkg.sv
// Purpose: Shared constants, state encoding and decode helpers of the sensor register bank.
// Assumes: One core clock; the converter hands over results on that clock.
// Notes: Offsets are register-select values, not byte addresses.
package tsrb_pkg;

  // Register-select values.
  localparam logic [1:0] SEL_TEMP = 2'h0;
  localparam logic [1:0] SEL_CONF = 2'h1;
  localparam logic [1:0] SEL_HYST = 2'h2;
  localparam logic [1:0] SEL_OVER = 2'h3;
  localparam logic [1:0] SEL_RESET = 2'h0;

  // Reset values.
  localparam logic [7:0] CONF_RESET = 8'h00;
  localparam logic [15:0] HYST_RESET = 16'h4b00;
  localparam logic [15:0] OVER_RESET = 16'h5000;
  localparam logic [10:0] TEMP_RESET = 11'h000;

  // Configuration field positions.
  localparam int CONF_SHDN_BIT = 0;
  localparam int CONF_MODE_BIT = 1;
  localparam int CONF_POL_BIT = 2;
  localparam int CONF_FQ_LSB = 3;
  localparam int CONF_RSV_LSB = 5;

  // Data layout of the 16-bit words.
  localparam int TEMP_W = 11;
  localparam int TEMP_LSB = 5;
  localparam int LIMIT_W = 9;
  localparam int LIMIT_LSB = 7;

  // Fixed upper part of the 7-bit bus address, and synchroniser width.
  localparam logic [3:0] ADDR_PREFIX = 4'h9;
  localparam int SYNC_W = 5;

  // Bus engine states, Gray coded along the write path; ST_SACK to ST_TXB changes two bits.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_SACK = 3'h3,
    ST_RXB  = 3'h2,
    ST_TXB  = 3'h6,
    ST_MACK = 3'h7
  } tsrb_state_t;

  // Number of consecutive faults that the queue setting asks for.
  function automatic logic [2:0] tsrb_queue_need(input logic [1:0] sel);
    case (sel)
      2'h0: tsrb_queue_need = 3'h1;
      2'h1: tsrb_queue_need = 3'h2;
      2'h2: tsrb_queue_need = 3'h4;
      default: tsrb_queue_need = 3'h6;
    endcase
  endfunction

endpackage

// file: inc/tsrb_alarm_if.sv
// Purpose: Carries comparison inputs and settings from the register bank to the alarm logic.
// Assumes: Both ends run on the core clock.
// Notes: conv_done is a one-cycle pulse, read_evt likewise.
`timescale 1ns/1ns
interface tsrb_alarm_if;
  logic conv_done;
  logic signed [8:0] temp9;
  logic signed [8:0] over9;
  logic signed [8:0] hyst9;
  logic [1:0] fq_sel;
  logic mode_irq;
  logic pol;
  logic shutdown;
  logic read_evt;
  logic level;
  logic active;

  modport bank (
    output conv_done, temp9, over9, hyst9, fq_sel, mode_irq, pol, shutdown, read_evt,
    input level, active
  );
  modport alarm (
    input conv_done, temp9, over9, hyst9, fq_sel, mode_irq, pol, shutdown, read_evt,
    output level, active
  );
endinterface

// file: logic/tsrb_sync.sv
// Purpose: Two-stage synchronisers for the bus pins and address straps.
// Assumes: Inputs are asynchronous to core_clk.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ns
module tsrb_sync
  import tsrb_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Raw and synchronised levels.
  input wire logic [SYNC_W-1:0] async_in,
  output logic [SYNC_W-1:0] sync_out
);

  // One independent two-flop chain per bit; the first stage feeds only the second.
  // Stages reset high, the idle level of the bus lines, so no false edge follows reset.
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_bit
      logic meta_ff;
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          meta_ff <= 1'b1;
          sync_out[gi] <= 1'b1;
        end else begin
          meta_ff <= async_in[gi];
          sync_out[gi] <= meta_ff;
        end
      end
    end
  endgenerate

endmodule

// file: logic/tsrb_alarm.sv
// Purpose: Limit comparison, fault queue and alarm output state.
// Assumes: conv_done pulses in the first cycle in which the result register holds its new value.
// Notes: The over limit must stay above the hysteresis limit, else the state is meaningless.
`timescale 1ns/1ns
module tsrb_alarm
  import tsrb_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Settings in, alarm state out.
  tsrb_alarm_if.alarm alm
);

  logic active_ff;
  logic arm_over_ff;
  logic [2:0] cnt_ff;
  logic level_ff;
  logic shdn_q_ff;
  logic nxt_active;

  // Comparison on the nine upper result bits against the limits.
  wire over_hit = alm.temp9 > alm.over9;
  wire under_hit = alm.temp9 < alm.hyst9;
  // Comparator mode looks for the crossing that would flip the output; interrupt
  // mode alternates between the two limits after each trip.
  wire seek_over = alm.mode_irq ? arm_over_ff : ~active_ff;
  wire fault = seek_over ? over_hit : under_hit;
  wire [2:0] need = tsrb_queue_need(alm.fq_sel);
  wire trip = alm.conv_done & fault & ((cnt_ff + 3'h1) >= need);
  wire shdn_rise = alm.shutdown & ~shdn_q_ff;
  wire irq_clear = alm.mode_irq & (alm.read_evt | shdn_rise);

  // A trip wins over a clear arriving in the same cycle, so no event is lost.
  always_comb begin
    nxt_active = active_ff;
    if (trip) begin
      nxt_active = alm.mode_irq | ~active_ff;
    end else if (irq_clear) begin
      nxt_active = 1'b0;
    end
  end

  // Alarm state, queue counter and polarity stage.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      active_ff <= 1'b0;
      arm_over_ff <= 1'b1;
      cnt_ff <= 3'h0;
      level_ff <= 1'b1;
      shdn_q_ff <= 1'b0;
    end else begin
      active_ff <= nxt_active;
      shdn_q_ff <= alm.shutdown;
      if (trip && alm.mode_irq) begin
        arm_over_ff <= ~arm_over_ff;
      end
      if (alm.conv_done) begin
        cnt_ff <= (fault && !trip) ? cnt_ff + 3'h1 : 3'h0;
      end
      level_ff <= active_ff ~^ alm.pol;
    end
  end

  assign alm.level = level_ff;
  assign alm.active = active_ff;

  a_queue_single: assert property (@(posedge core_clk) disable iff (rst)
    (alm.conv_done && fault && cnt_ff == 3'h0 && alm.fq_sel == 2'h0)
      |=> (active_ff != $past(active_ff) || $past(alm.mode_irq)))
    else $error("single-fault queue did not trip");

  a_queue_hold: assert property (@(posedge core_clk) disable iff (rst)
    (alm.conv_done && fault && cnt_ff == 3'h0 && alm.fq_sel == 2'h3 && !irq_clear)
      |=> active_ff == $past(active_ff))
    else $error("six-fault queue tripped on first fault");

  a_irq_read_clear: assert property (@(posedge core_clk) disable iff (rst)
    (alm.mode_irq && alm.read_evt && !trip) |=> !active_ff)
    else $error("interrupt alarm not cleared by read");

  a_alarm_polarity: assert property (@(posedge core_clk) disable iff (rst)
    ##1 level_ff == ($past(active_ff) ~^ $past(alm.pol)))
    else $error("alarm level has wrong polarity");

  a_comp_read_keep: assert property (@(posedge core_clk) disable iff (rst)
    (!alm.mode_irq && !alm.conv_done) |=> active_ff == $past(active_ff))
    else $error("comparator alarm changed without conversion");

endmodule

// file: logic/tsrb_bank.sv
// Purpose: Register bank of a temperature sensor answering as a two-wire bus target.
// Assumes: Bus clock well below a quarter of core_clk; converter on core_clk.
// Notes: Pins are open drain; an enable high means the pin is pulled low.
`timescale 1ns/1ns

module tsrb_bank
  import tsrb_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Two-wire bus pins.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps.
  input wire logic [2:0] addr_pins,
  // Converter hand-over.
  input wire logic [10:0] temp_sample,
  input wire logic conv_done,
  output logic conv_run,
  // Alarm pin and its level.
  output logic alarm_output,
  output logic alarm_output_out,
  output logic alarm_output_oe
);

  tsrb_state_t state_ff;
  tsrb_state_t nxt_state;
  logic scl_s;
  logic sda_s;
  logic [2:0] addr_s;
  logic scl_q_ff;
  logic sda_q_ff;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_bit_cnt;
  logic [7:0] shift_ff;
  logic [1:0] byte_idx_ff;
  logic rw_ff;
  logic rd_low_ff;
  logic host_ack_ff;
  logic sda_oe_ff;
  logic nxt_oe;
  logic [7:0] tx_byte_ff;
  logic [7:0] hi_buf_ff;
  logic [1:0] sel_ff;
  logic [7:0] conf_ff;
  logic [LIMIT_W-1:0] hyst_ff;
  logic [LIMIT_W-1:0] over_ff;
  logic [TEMP_W-1:0] temp_ff;
  logic cmp_ff;
  logic [15:0] rd_word;

  tsrb_alarm_if alm ();

  // Bus pins and straps come from outside the clock domain.
  tsrb_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({scl_in, sda_in, addr_pins}),
    .sync_out({scl_s, sda_s, addr_s})
  );

  tsrb_alarm u_alarm (
    .core_clk(core_clk),
    .rst(rst),
    .alm(alm)
  );

  // Edge and condition detection on the synchronised bus levels.
  wire scl_rise = scl_s & ~scl_q_ff;
  wire scl_fall = ~scl_s & scl_q_ff;
  wire bus_start = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  wire bus_stop = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  wire byte_done = scl_fall & (bit_cnt_ff == 4'h8);
  wire addr_hit = shift_ff[7:1] == {ADDR_PREFIX, addr_s};

  // Decode of received bytes: byte 0 is the select byte, then data bytes.
  wire rx_byte = (state_ff == ST_RXB) & byte_done;
  wire sel_load = rx_byte & (byte_idx_ff == 2'h0);
  wire data_hi = rx_byte & (byte_idx_ff == 2'h1);
  wire data_lo = rx_byte & (byte_idx_ff == 2'h2);
  wire conf_wr = data_hi & (sel_ff == SEL_CONF);
  wire hyst_wr = data_lo & (sel_ff == SEL_HYST);
  wire over_wr = data_lo & (sel_ff == SEL_OVER);
  wire read_start = (state_ff == ST_ADDR) & byte_done & addr_hit & shift_ff[0];
  wire load_tx = scl_fall & (((state_ff == ST_SACK) & rw_ff)
                 | ((state_ff == ST_MACK) & host_ack_ff));
  wire conv_accept = conv_done & ~conf_ff[CONF_SHDN_BIT];

  // Read word by select value; stored bits with zero below them, except the configuration byte, which fills both halves.
  always_comb begin
    case (sel_ff)
      SEL_TEMP: rd_word = {temp_ff, 5'h00};
      SEL_CONF: rd_word = {conf_ff, conf_ff};
      SEL_HYST: rd_word = {hyst_ff, 7'h00};
      default: rd_word = {over_ff, 7'h00};
    endcase
  end

  // The select byte itself is never a read source.
  wire [7:0] rd_byte = rd_low_ff ? rd_word[7:0] : rd_word[15:8];

  // Bus engine: acknowledges, steps through bytes and shapes the data line.
  always_comb begin
    nxt_state = state_ff;
    nxt_oe = sda_oe_ff;
    nxt_bit_cnt = bit_cnt_ff;
    if (scl_rise) begin
      nxt_bit_cnt = bit_cnt_ff + 4'h1;
    end
    case (state_ff)
      ST_IDLE: begin
        nxt_oe = 1'b0;
      end
      ST_ADDR: begin
        if (byte_done) begin
          nxt_state = addr_hit ? ST_SACK : ST_IDLE;
          nxt_oe = addr_hit;
        end
      end
      ST_RXB: begin
        if (byte_done) begin
          nxt_state = ST_SACK;
          nxt_oe = 1'b1;
        end
      end
      ST_SACK: begin
        if (scl_fall) begin
          nxt_bit_cnt = 4'h0;
          nxt_state = rw_ff ? ST_TXB : ST_RXB;
          nxt_oe = rw_ff & ~rd_byte[7];
        end
      end
      ST_TXB: begin
        if (scl_fall) begin
          if (bit_cnt_ff == 4'h8) begin
            nxt_state = ST_MACK;
            nxt_oe = 1'b0;
          end else begin
            nxt_oe = ~tx_byte_ff[3'h7 - bit_cnt_ff[2:0]];
          end
        end
      end
      ST_MACK: begin
        // A host that stops acknowledging ends the read, even after one byte.
        if (scl_fall) begin
          nxt_bit_cnt = 4'h0;
          nxt_state = host_ack_ff ? ST_TXB : ST_IDLE;
          nxt_oe = host_ack_ff & ~rd_byte[7];
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_oe = 1'b0;
      end
    endcase
    if (bus_start) begin
      nxt_state = ST_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_oe = 1'b0;
    end else if (bus_stop) begin
      nxt_state = ST_IDLE;
      nxt_oe = 1'b0;
    end
  end

  // Engine registers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
      // Delayed levels start at the idle bus level to match the synchronisers.
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      sda_oe_ff <= nxt_oe;
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  // Byte shifter, byte position and read sequencing.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_ff <= 8'h00;
      byte_idx_ff <= 2'h0;
      rw_ff <= 1'b0;
      rd_low_ff <= 1'b0;
      host_ack_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
      hi_buf_ff <= 8'h00;
    end else begin
      if (scl_rise && (state_ff == ST_ADDR || state_ff == ST_RXB)) begin
        shift_ff <= {shift_ff[6:0], sda_s};
      end
      if (scl_rise && state_ff == ST_MACK) begin
        host_ack_ff <= ~sda_s;
      end
      if (bus_start) begin
        byte_idx_ff <= 2'h0;
        rd_low_ff <= 1'b0;
      end else if (rx_byte && byte_idx_ff != 2'h3) begin
        byte_idx_ff <= byte_idx_ff + 2'h1;
      end else if (load_tx) begin
        rd_low_ff <= ~rd_low_ff;
      end
      if ((state_ff == ST_ADDR) && byte_done) begin
        rw_ff <= shift_ff[0];
      end
      if (load_tx) begin
        tx_byte_ff <= rd_byte;
      end
      if (data_hi) begin
        hi_buf_ff <= shift_ff;
      end
    end
  end

  // Register file; the result register takes converter data only.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_ff <= SEL_RESET;
      conf_ff <= CONF_RESET;
      hyst_ff <= HYST_RESET[15:LIMIT_LSB];
      over_ff <= OVER_RESET[15:LIMIT_LSB];
      temp_ff <= TEMP_RESET;
      cmp_ff <= 1'b0;
    end else begin
      if (sel_load) begin
        sel_ff <= shift_ff[1:0];
      end
      if (conf_wr) begin
        conf_ff <= shift_ff;
      end
      if (hyst_wr) begin
        hyst_ff <= {hi_buf_ff, shift_ff[7]};
      end
      if (over_wr) begin
        over_ff <= {hi_buf_ff, shift_ff[7]};
      end
      if (conv_accept) begin
        temp_ff <= temp_sample;
      end
      cmp_ff <= conv_accept;
    end
  end

  // Settings and the fresh result toward the alarm logic.
  assign alm.conv_done = cmp_ff;
  assign alm.temp9 = temp_ff[TEMP_W-1:TEMP_W-LIMIT_W];
  assign alm.over9 = over_ff;
  assign alm.hyst9 = hyst_ff;
  assign alm.fq_sel = conf_ff[CONF_FQ_LSB+1:CONF_FQ_LSB];
  assign alm.mode_irq = conf_ff[CONF_MODE_BIT];
  assign alm.pol = conf_ff[CONF_POL_BIT];
  assign alm.shutdown = conf_ff[CONF_SHDN_BIT];
  assign alm.read_evt = read_start;

  // Pins: open drain, so the driven value is always low.
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_ff;
  assign alarm_output = alm.level;
  assign alarm_output_out = 1'b0;
  assign alarm_output_oe = ~alm.level;
  assign conv_run = ~conf_ff[CONF_SHDN_BIT];

  a_sel_latch: assert property (@(posedge core_clk) disable iff (rst)
    sel_load |=> sel_ff == $past(shift_ff[1:0]))
    else $error("select value not latched");

  a_temp_low_zero: assert property (@(posedge core_clk) disable iff (rst)
    (load_tx && sel_ff == SEL_TEMP && rd_low_ff) |=> tx_byte_ff[4:0] == 5'h00)
    else $error("result low bits not zero");

  a_limit_low_zero: assert property (@(posedge core_clk) disable iff (rst)
    (load_tx && sel_ff[1] && rd_low_ff) |=> tx_byte_ff[6:0] == 7'h00)
    else $error("limit low bits not zero");

  a_temp_read_only: assert property (@(posedge core_clk) disable iff (rst)
    (rx_byte && sel_ff == SEL_TEMP && !conv_accept) |=> $stable(temp_ff))
    else $error("result register changed by a write");

  a_temp_update: assert property (@(posedge core_clk) disable iff (rst)
    conv_accept |=> (temp_ff == $past(temp_sample)) && alm.conv_done)
    else $error("result not updated at conversion end");

  a_shutdown_noconv: assert property (@(posedge core_clk) disable iff (rst)
    conf_ff[CONF_SHDN_BIT] |-> (!conv_accept && !conv_run))
    else $error("conversion accepted in shutdown");

  a_conf_readback: assert property (@(posedge core_clk) disable iff (rst)
    (load_tx && sel_ff == SEL_CONF) |=> tx_byte_ff == $past(conf_ff))
    else $error("configuration read differs from stored byte");

endmodule

// file: verif/tsrb_host.sv
// Purpose: Behavioural two-wire bus controller that drives the sensor register bank.
// Assumes: SCL period of 8 core cycles; SDA is open drain with a pull-up, SCL is driven directly.
// Notes: SCL stands high between frames; SDA moves late in the low phase.
`timescale 1ns/1ns
module tsrb_host (
  // Clock.
  input wire logic core_clk,
  // Bus lines and target address.
  input wire logic sda_wire,
  input wire logic [6:0] tgt_addr,
  output logic scl,
  output logic sda_pull
);
  int dev_nacks;

  // Idle bus: both lines released.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    dev_nacks = 0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // SDA settles three cycles into the low phase so the target's synchroniser sees it first.
  task automatic bit_io(input logic pull, output logic seen);
    wait_n(3);
    sda_pull = pull;
    wait_n(1);
    scl = 1'b1;
    wait_n(3);
    seen = sda_wire;
    wait_n(1);
    scl = 1'b0;
  endtask

  // A start from a low SCL is a repeated start.
  task automatic start();
    if (scl === 1'b0) begin
      wait_n(3);
      sda_pull = 1'b0;
      wait_n(1);
      scl = 1'b1;
      wait_n(4);
    end
    sda_pull = 1'b1;
    wait_n(4);
    scl = 1'b0;
  endtask

  task automatic stop();
    wait_n(3);
    sda_pull = 1'b1;
    wait_n(1);
    scl = 1'b1;
    wait_n(4);
    sda_pull = 1'b0;
    wait_n(8);
  endtask

  // Sends a byte, first bit highest, and counts a missing acknowledge.
  task automatic put_byte(input logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_io(~b[i], seen);
    end
    bit_io(1'b0, seen);
    if (seen !== 1'b0) begin
      dev_nacks++;
    end
  endtask

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b0, seen);
      b[i] = seen;
    end
    bit_io(~last, seen);
  endtask

  // Write: select byte straight after the address, then zero to two data bytes.
  task automatic wr(input logic [7:0] sel, input int n, input logic [15:0] d);
    start();
    put_byte({tgt_addr, 1'b0});
    put_byte(sel);
    if (n == 2) begin
      put_byte(d[15:8]);
    end
    if (n >= 1) begin
      put_byte(d[7:0]);
    end
    stop();
  endtask

  // Read of one or two bytes using the latched select.
  task automatic rd(input int n, output logic [15:0] d);
    logic [7:0] b0;
    logic [7:0] b1;
    start();
    put_byte({tgt_addr, 1'b1});
    get_byte(n == 1, b0);
    b1 = 8'h00;
    if (n == 2) begin
      get_byte(1'b1, b1);
    end
    d = (n == 2) ? {b0, b1} : {8'h00, b0};
    stop();
  endtask
endmodule

// file: verif/tb.sv
// Purpose: Self-checking bench of the sensor register bank over its two-wire bus.
// Assumes: Converter results are pulsed in by the bench on core_clk.
// Notes: Alarm checks wait four cycles after each conversion pulse.
`timescale 1ns/1ns
module tb
  import tsrb_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr_pins = 3'h5;
  logic [6:0] tgt = {ADDR_PREFIX, 3'h5};
  logic [10:0] temp_sample = 11'h000;
  logic conv_done = 1'b0;
  logic scl, sda_pull, sda_wire, sda_out, sda_oe, conv_run;
  logic alarm_output, alarm_output_out, alarm_output_oe;
  int fail_count = 0;
  int n_checks = 0;

  // Clock and the pulled-up data wire.
  always #20 core_clk = ~core_clk;
  assign sda_wire = ~(sda_pull | sda_oe);

  tsrb_bank u_tsrb_bank (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_pins(addr_pins), .temp_sample(temp_sample),
    .conv_done(conv_done), .conv_run(conv_run), .alarm_output(alarm_output),
    .alarm_output_out(alarm_output_out), .alarm_output_oe(alarm_output_oe));
  tsrb_host u_tsrb_host (.core_clk(core_clk), .sda_wire(sda_wire), .tgt_addr(tgt), .scl(scl),
    .sda_pull(sda_pull));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(negedge core_clk);
    rst = 1'b1;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask

  // One finished conversion, then time for the alarm to settle.
  task automatic conv(input logic [10:0] s);
    @(negedge core_clk);
    temp_sample = s;
    conv_done = 1'b1;
    @(negedge core_clk);
    conv_done = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic t_reset();
    logic [15:0] d;
    int n0;
    chk("conv_run", conv_run, 16'h0001);
    chk("alarm idle", alarm_output, 16'h0001);
    chk("alarm pin released", alarm_output_oe, 16'h0000);
    chk("alarm drive value", alarm_output_out, 16'h0000);
    chk("data drive value", sda_out, 16'h0000);
    u_tsrb_host.rd(2, d);
    chk("result at reset", d, {TEMP_RESET, 5'h00});
    u_tsrb_host.wr(8'h01, 0, 16'h0000);
    u_tsrb_host.rd(1, d);
    chk("conf at reset", d, {8'h00, CONF_RESET});
    u_tsrb_host.wr(8'h02, 0, 16'h0000);
    u_tsrb_host.rd(2, d);
    chk("hysteresis at reset", d, HYST_RESET);
    u_tsrb_host.wr(8'h03, 0, 16'h0000);
    u_tsrb_host.rd(2, d);
    chk("over at reset", d, OVER_RESET);
    n0 = u_tsrb_host.dev_nacks;
    tgt = tgt ^ 7'h01;
    u_tsrb_host.rd(1, d);
    tgt = tgt ^ 7'h01;
    chk("foreign address refused", 16'(u_tsrb_host.dev_nacks - n0), 16'h0001);
    $display("t_reset done");
  endtask

  task automatic t_temp();
    logic [15:0] d;
    conv(11'h649);
    u_tsrb_host.wr(8'h00, 0, 16'h0000);
    u_tsrb_host.rd(2, d);
    chk("result word", d, {11'h649, 5'h00});
    u_tsrb_host.rd(1, d);
    chk("result high byte", d, {8'h00, 8'hc9});
    u_tsrb_host.wr(8'h00, 2, 16'h1234);
    u_tsrb_host.rd(2, d);
    chk("result after write", d, {11'h649, 5'h00});
    $display("t_temp done");
  endtask

  task automatic t_regs();
    logic [15:0] d;
    u_tsrb_host.wr(8'h02, 2, 16'h12ff);
    u_tsrb_host.wr(8'h03, 2, 16'h7fff);
    u_tsrb_host.wr(8'h02, 0, 16'h0000);
    u_tsrb_host.rd(2, d);
    chk("hysteresis word", d, 16'h1280);
    u_tsrb_host.wr(8'h03, 0, 16'h0000);
    u_tsrb_host.rd(2, d);
    chk("over word", d, 16'h7f80);
    u_tsrb_host.wr(8'h01, 1, 16'h00f8);
    u_tsrb_host.rd(2, d);
    chk("conf both bytes", d, 16'hf8f8);
    $display("t_regs done");
  endtask

  // Comparator mode with every fault queue setting.
  task automatic t_comp();
    logic [15:0] d;
    int need;
    u_tsrb_host.wr(8'h03, 2, 16'h1900);
    u_tsrb_host.wr(8'h02, 2, 16'h1400);
    u_tsrb_host.wr(8'h01, 1, 16'h0000);
    conv(11'h0cb);
    chk("nine bit compare", alarm_output, 16'h0001);
    for (int q = 0; q < 4; q++) begin
      need = (q == 0) ? 1 : q * 2;
      u_tsrb_host.wr(8'h01, 1, 16'(q << 3));
      repeat (need - 1) conv(11'h0cc);
      chk("alarm before queue full", alarm_output, 16'h0001);
      conv(11'h0cc);
      chk("alarm at queue full", alarm_output, 16'h0000);
      u_tsrb_host.rd(1, d);
      chk("comparator keeps on read", alarm_output, 16'h0000);
      repeat (need) conv(11'h09c);
      chk("alarm off below hysteresis", alarm_output, 16'h0001);
    end
    $display("t_comp done");
  endtask

  // Interrupt mode, shutdown and polarity, from a fresh reset.
  task automatic t_irq();
    logic [15:0] d;
    do_reset();
    u_tsrb_host.wr(8'h01, 1, 16'h0002);
    conv(11'h284);
    chk("interrupt over trip", alarm_output, 16'h0000);
    u_tsrb_host.rd(1, d);
    chk("cleared by read", alarm_output, 16'h0001);
    conv(11'h284);
    chk("no repeat over trip", alarm_output, 16'h0001);
    conv(11'h254);
    chk("hysteresis trip", alarm_output, 16'h0000);
    u_tsrb_host.wr(8'h01, 1, 16'h0003);
    chk("shutdown clears", alarm_output, 16'h0001);
    chk("converter stopped", conv_run, 16'h0000);
    conv(11'h100);
    u_tsrb_host.wr(8'h00, 0, 16'h0000);
    u_tsrb_host.rd(2, d);
    chk("result held in shutdown", d, {11'h254, 5'h00});
    u_tsrb_host.wr(8'h01, 1, 16'h0004);
    chk("converter resumed", conv_run, 16'h0001);
    chk("active high idle level", alarm_output, 16'h0000);
    chk("pin enable", alarm_output_oe, 16'h0001);
    $display("t_irq done");
  endtask

  // Main sequence.
  initial begin
    do_reset();
    t_reset();
    t_temp();
    t_regs();
    t_comp();
    t_irq();
    give_verdict();
  end

  // Cuts a hang short well inside the run budget.
  initial begin
    repeat (90000) @(posedge core_clk);
    fail_count++;
    $display("mismatch watchdog expected finish seen timeout");
    give_verdict();
  end
endmodule
